// ### src/cas_defs.svh
// Constants of the current ADC scaler and selector
`ifndef CAS_DEFS_SVH
`define CAS_DEFS_SVH

// Register indexes on the register port
`define CAS_ADDR_RAW_PAIR      7'h02
`define CAS_ADDR_OFS_GAIN_SEC  7'h08
`define CAS_ADDR_OFS_GAIN_FST  7'h09

// Field positions inside the offset/gain and raw pair words
`define CAS_LO_LSB             0
`define CAS_HI_LSB             16

// Reset values
`define CAS_OFFSET_RST         16'h8000
`define CAS_GAIN_RST           16'h0100
`define CAS_DEC_LOG2_RST       3'h5

// Raw code mapping
`define CAS_RAW_SCALED_MID     17'h08000
`define CAS_RAW_MID_CODE       16'h7fff
`define CAS_RAW_FULL           16'hffff
`define CAS_RAW_BITS           5'h10

// Q8.8 gain: division by 256 is a shift by this amount
`define CAS_GAIN_SHIFT         8

// Signed 16-bit limits
`define CAS_S16_MAX            16'h7fff
`define CAS_S16_MIN            16'h8000

`endif

// ### src/cas_pkg.sv
// Types shared by the current ADC scaler and selector
package cas_pkg;

    // Modulator group configuration
    typedef enum logic [1:0] {
        cas_mode_analog  = 2'b00,
        cas_mode_clk_out = 2'b01,
        cas_mode_clk_in  = 2'b10,
        cas_mode_cmp_fb  = 2'b11
    } cas_mod_mode_t;

    // Sources of a raw current slot
    typedef enum logic [1:0] {
        cas_src_int_u = 2'b00,
        cas_src_int_v = 2'b01,
        cas_src_ext_0 = 2'b10,
        cas_src_ext_1 = 2'b11
    } cas_raw_src_t;

    // Sources of a phase-current output
    typedef enum logic [1:0] {
        cas_ph_first  = 2'b00,
        cas_ph_second = 2'b01,
        cas_ph_third  = 2'b10
    } cas_phase_src_t;

    // One set of phase currents handed to the control datapath
    typedef struct packed {
        logic signed [15:0] ux;
        logic signed [15:0] v;
        logic signed [15:0] wy;
    } cas_phase_word_t;

endpackage

// ### src/cas_scaler.sv
// Modulator filters, raw selection, scaling and phase mapping
//
// Notes on behaviour
// - Raw words are unsigned 16-bit, zero to all ones
// - Density maps linearly: quarter 4000, half 7fff
// - Config forces internal inputs to fixed levels
// - Same sinc filter for internal and external
// - External mode disables the fast debug port
// - Debug UART stays enabled in every mode
// - External channel: bitstream pin plus clock pin
// - External mode turns analog pin digital
// - Raw values left-aligned to 16 bits
// - Currents leave as signed 16-bit values
// - Corrected = (raw - offset) * gain / 256
// - Two selectors route four sources to slots
// - Offset subtraction centres values on zero
// - Three-phase derives third current summing zero
// - Two-phase computes no third current
// - Three selectors map currents onto phases
// - Two-phase uses only UX and WY outputs
// - Both raw slots readable at index 02
// - Offset/gain second at 08, first at 09
// - Group modes: analog, clock out/in, comparator
// - Sinc3 decimation gives word per count
// - Modulator clock from 32-bit increment NCO
`include "cas_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Phase-word FIFO between the scaler and the control datapath
module cas_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } cas_fifo_st_t;

    cas_fifo_st_t s;
    cas_fifo_st_t next_s;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("cas_fifo depth must be a power of two");
    end

    // Full when pointers differ by the depth, empty when equal
    assign o_in_ready  = (s.wp - s.rp) != (AW + 1)'(DEPTH);
    assign o_out_valid = s.wp != s.rp;
    assign o_out_data  = s.mem[s.rp[AW-1:0]];

    // Push and pop
    always_comb begin
        next_s = s;
        if (i_in_valid && o_in_ready) begin
            next_s.mem[s.wp[AW-1:0]] = i_in_data;
            next_s.wp = s.wp + 1'b1;
        end
        if (o_out_valid && i_out_ready) begin
            next_s.rp = s.rp + 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// Current measurement back end
module cas_scaler #(
    parameter int DEC_LOG2_MAX = 5,
    parameter int FIFO_DEPTH   = 8
) (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_resetn,
    input  wire logic [6:0]              i_reg_addr,
    input  wire logic                    i_reg_wr,
    input  wire logic [31:0]             i_reg_wdata,
    output logic [31:0]                  o_reg_rdata,
    input  wire logic [3:0]              i_modulator_bitstream,
    input  wire logic [1:0]              i_mclk_in,
    output logic [1:0]                   o_mclk_out,
    output logic [1:0]                   o_mclk_oe_n,
    output logic                         o_int_mclk,
    input  wire cas_pkg::cas_mod_mode_t  i_mod_mode,
    input  wire logic [31:0]             i_mclk_increment,
    input  wire logic [2:0]              i_decimation_log2,
    input  wire logic [3:0]              i_input_stage_config,
    output logic [3:0]                   o_input_stage_config,
    output logic                         o_ext_pin_digital,
    output logic                         o_fast_debug_enable,
    output logic                         o_uart_enable,
    input  wire cas_pkg::cas_raw_src_t   i_raw_source_sel_first,
    input  wire cas_pkg::cas_raw_src_t   i_raw_source_sel_second,
    input  wire cas_pkg::cas_phase_src_t i_phase_ux_source_sel,
    input  wire cas_pkg::cas_phase_src_t i_phase_v_source_sel,
    input  wire cas_pkg::cas_phase_src_t i_phase_wy_source_sel,
    input  wire logic                    i_three_phase_mode,
    output logic                         o_phase_valid,
    input  wire logic                    i_phase_ready,
    output cas_pkg::cas_phase_word_t     o_phase
);
    localparam int ACC_W = 3 * DEC_LOG2_MAX + 2;
    localparam int PW    = $bits(cas_pkg::cas_phase_word_t);

    if (DEC_LOG2_MAX < 1 || DEC_LOG2_MAX > 5) begin : g_chk
        $error("cas_scaler decimation exponent must be 1 to 5");
    end

    typedef struct packed {
        logic [31:0]                 acc;
        logic [5:0]                  sy1;
        logic [5:0]                  sy2;
        logic [5:0]                  sy3;
        logic [5:0]                  filt;
        logic [1:0]                  mclk_prev;
        logic [3:0][ACC_W-1:0]       i1;
        logic [3:0][ACC_W-1:0]       i2;
        logic [3:0][ACC_W-1:0]       i3;
        logic [3:0][ACC_W-1:0]       d1;
        logic [3:0][ACC_W-1:0]       d2;
        logic [3:0][ACC_W-1:0]       d3;
        logic [3:0][4:0]             dcnt;
        logic [3:0][15:0]            raw;
        logic [15:0]                 raw_first;
        logic [15:0]                 raw_second;
        logic                        new_raw;
        logic [15:0]                 ofs0;
        logic [15:0]                 gain0;
        logic [15:0]                 ofs1;
        logic [15:0]                 gain1;
        logic                        s2_valid;
        cas_pkg::cas_phase_word_t    s2_word;
        logic                        out_valid;
        cas_pkg::cas_phase_word_t    out_word;
        logic [31:0]                 rdata;
        logic [1:0]                  mclk_out;
        logic [1:0]                  mclk_oe_n;
        logic                        int_mclk;
        logic [3:0]                  isc;
        logic                        ext_digital;
        logic                        dbg_en;
        logic                        uart_en;
    } cas_state_t;

    cas_state_t               s;
    cas_state_t               next_s;
    logic [1:0]               rst_sync;
    logic                     rst_n;
    logic                     fifo_in_ready;
    logic                     fifo_out_valid;
    logic                     fifo_out_ready;
    logic [PW-1:0]            fifo_out_data;
    logic signed [15:0]       corr0;
    logic signed [15:0]       corr1;
    logic signed [15:0]       third;
    logic                     take;

    // Reset release through two flip-flops
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Clamp a wide signed value into the signed 16-bit range
    function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
        if (v > 34'sd32767) begin
            sat16 = `CAS_S16_MAX;
        end else if (v < -34'sd32768) begin
            sat16 = `CAS_S16_MIN;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    // Offset removal and Q8.8 gain
    function automatic logic signed [15:0] scale(input logic [15:0] raw,
                                                  input logic [15:0] ofs,
                                                  input logic [15:0] gain);
        logic signed [16:0] diff;
        logic signed [33:0] prod;
        diff  = $signed({1'b0, raw}) - $signed({1'b0, ofs});
        prod  = 34'(diff) * 34'($signed(gain));
        scale = sat16(prod >>> `CAS_GAIN_SHIFT);
    endfunction

    // Phase output source mux
    function automatic logic signed [15:0] pick(
        input cas_pkg::cas_phase_src_t sel, input logic signed [15:0] a,
        input logic signed [15:0] b, input logic signed [15:0] c);
        unique case (sel)
            cas_pkg::cas_ph_first:  pick = a;
            cas_pkg::cas_ph_second: pick = b;
            cas_pkg::cas_ph_third:  pick = c;
            default:                pick = a;
        endcase
    endfunction

    // Corrected currents and the derived third one
    assign corr0 = scale(s.raw_first, s.ofs0, s.gain0);
    assign corr1 = scale(s.raw_second, s.ofs1, s.gain1);
    assign third = i_three_phase_mode ?
                   sat16(-(34'(corr0) + 34'(corr1))) : 16'sh0000;
    assign take  = s.new_raw && (!s.s2_valid || fifo_in_ready);
    assign fifo_out_ready = !s.out_valid || i_phase_ready;

    cas_fifo #(
        .WIDTH (PW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (rst_n),
        .i_in_valid  (s.s2_valid),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (s.s2_word),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_out_ready),
        .o_out_data  (fifo_out_data)
    );

    // Next-state logic of the whole block
    always_comb begin
        logic [3:0]       tick;
        logic [3:0]       strobe;
        logic [2:0]       k;
        logic [4:0]       sh;
        logic [4:0]       last;
        logic [ACC_W-1:0] c1;
        logic [ACC_W-1:0] c2;
        logic [ACC_W-1:0] c3;
        logic [16:0]      sc;
        logic             nco_tick;
        logic             ext_mode;
        tick     = '0;
        strobe   = '0;
        k        = '0;
        sh       = '0;
        last     = '0;
        nco_tick = 1'b0;
        ext_mode = 1'b0;
        c1       = '0;
        c2       = '0;
        c3       = '0;
        sc       = '0;
        next_s   = s;

        // Modulator clock NCO
        next_s.acc = s.acc + i_mclk_increment;
        nco_tick   = !s.acc[31] && next_s.acc[31];
        next_s.int_mclk = next_s.acc[31];

        // Three-stage pin synchronisers, change taken when stages agree
        next_s.sy1 = {i_mclk_in, i_modulator_bitstream};
        next_s.sy2 = s.sy1;
        next_s.sy3 = s.sy2;
        for (int p = 0; p < 6; p++) begin
            if (s.sy2[p] == s.sy3[p]) begin
                next_s.filt[p] = s.sy3[p];
            end
        end
        next_s.mclk_prev = s.filt[5:4];

        // Group mode drives clock pins and pin roles
        ext_mode = i_mod_mode != cas_pkg::cas_mode_analog;
        next_s.ext_digital = ext_mode;
        next_s.dbg_en      = !ext_mode;
        next_s.uart_en     = 1'b1;
        next_s.isc         = i_input_stage_config;
        for (int j = 0; j < 2; j++) begin
            unique case (i_mod_mode)
                cas_pkg::cas_mode_analog: begin
                    next_s.mclk_oe_n[j] = 1'b1;
                    next_s.mclk_out[j]  = 1'b0;
                end
                cas_pkg::cas_mode_clk_out: begin
                    next_s.mclk_oe_n[j] = 1'b0;
                    next_s.mclk_out[j]  = next_s.acc[31];
                end
                cas_pkg::cas_mode_clk_in: begin
                    next_s.mclk_oe_n[j] = 1'b1;
                    next_s.mclk_out[j]  = 1'b0;
                end
                cas_pkg::cas_mode_cmp_fb: begin
                    next_s.mclk_oe_n[j] = 1'b0;
                    next_s.mclk_out[j]  = s.filt[2 + j];
                end
            endcase
        end

        // Sample ticks: NCO, except external clock edges on the external channels in clock-input mode
        tick[1:0] = {2{nco_tick}};
        for (int j = 0; j < 2; j++) begin
            tick[2 + j] = (i_mod_mode == cas_pkg::cas_mode_clk_in) ?
                          (s.filt[4 + j] && !s.mclk_prev[j]) : nco_tick;
        end

        // Decimation exponent clamped to the filter's range
        k = i_decimation_log2;
        if (k == 3'h0) begin
            k = 3'h1;
        end else if (k > 3'(DEC_LOG2_MAX)) begin
            k = 3'(DEC_LOG2_MAX);
        end
        last = 5'((32'h1 << k) - 1);
        sh   = `CAS_RAW_BITS - 5'(5'(k) * 5'h3);

        // Sinc3 filter and decimator, identical on every channel
        for (int c = 0; c < 4; c++) begin
            if (tick[c]) begin
                next_s.i1[c] = s.i1[c] + ACC_W'(s.filt[c]);
                next_s.i2[c] = s.i2[c] + s.i1[c];
                next_s.i3[c] = s.i3[c] + s.i2[c];
                next_s.dcnt[c] = s.dcnt[c] + 5'h1;
                if (s.dcnt[c] >= last) begin
                    c1 = s.i3[c] - s.d1[c];
                    c2 = c1 - s.d2[c];
                    c3 = c2 - s.d3[c];
                    next_s.d1[c] = s.i3[c];
                    next_s.d2[c] = c1;
                    next_s.d3[c] = c2;
                    next_s.dcnt[c] = 5'h0;
                    sc = 17'(c3) << sh;
                    if (sc[16]) begin
                        next_s.raw[c] = `CAS_RAW_FULL;
                    end else if (sc == `CAS_RAW_SCALED_MID) begin
                        next_s.raw[c] = `CAS_RAW_MID_CODE;
                    end else begin
                        next_s.raw[c] = sc[15:0];
                    end
                    strobe[c] = 1'b1;
                end
            end
        end

        // Raw current slot selectors
        if (strobe[i_raw_source_sel_first]) begin
            next_s.raw_first = next_s.raw[i_raw_source_sel_first];
        end
        if (strobe[i_raw_source_sel_second]) begin
            next_s.raw_second = next_s.raw[i_raw_source_sel_second];
        end
        // A new word wins over the hand-off in the same cycle
        next_s.new_raw = strobe[i_raw_source_sel_first] ||
                         strobe[i_raw_source_sel_second] ||
                         (s.new_raw && !take);

        // Scaling stage, stalled while the FIFO is full
        if (s.s2_valid && fifo_in_ready) begin
            next_s.s2_valid = 1'b0;
        end
        if (take) begin
            next_s.s2_valid   = 1'b1;
            next_s.s2_word.ux = pick(i_phase_ux_source_sel,
                                     corr0, corr1, third);
            next_s.s2_word.v  = pick(i_phase_v_source_sel,
                                     corr0, corr1, third);
            next_s.s2_word.wy = pick(i_phase_wy_source_sel,
                                     corr0, corr1, third);
        end

        // Output register toward the control datapath
        if (fifo_out_valid && fifo_out_ready) begin
            next_s.out_valid = 1'b1;
            next_s.out_word  = fifo_out_data;
        end else if (i_phase_ready) begin
            next_s.out_valid = 1'b0;
        end

        // Register port writes
        if (i_reg_wr && i_reg_addr == `CAS_ADDR_OFS_GAIN_SEC) begin
            next_s.ofs1  = i_reg_wdata[`CAS_LO_LSB +: 16];
            next_s.gain1 = i_reg_wdata[`CAS_HI_LSB +: 16];
        end
        if (i_reg_wr && i_reg_addr == `CAS_ADDR_OFS_GAIN_FST) begin
            next_s.ofs0  = i_reg_wdata[`CAS_LO_LSB +: 16];
            next_s.gain0 = i_reg_wdata[`CAS_HI_LSB +: 16];
        end

        // Register port reads, unmapped indexes read zero
        case (i_reg_addr)
            `CAS_ADDR_RAW_PAIR:     next_s.rdata = {s.raw_second,
                                                    s.raw_first};
            `CAS_ADDR_OFS_GAIN_SEC: next_s.rdata = {s.gain1, s.ofs1};
            `CAS_ADDR_OFS_GAIN_FST: next_s.rdata = {s.gain0, s.ofs0};
            default:                next_s.rdata = 32'h0000_0000;
        endcase
    end

    // State register
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s           <= '0;
            s.ofs0      <= `CAS_OFFSET_RST;
            s.ofs1      <= `CAS_OFFSET_RST;
            s.gain0     <= `CAS_GAIN_RST;
            s.gain1     <= `CAS_GAIN_RST;
            s.mclk_oe_n <= 2'b11;
            s.dbg_en    <= 1'b1;
            s.uart_en   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign o_reg_rdata          = s.rdata;
    assign o_mclk_out           = s.mclk_out;
    assign o_mclk_oe_n          = s.mclk_oe_n;
    assign o_int_mclk           = s.int_mclk;
    assign o_input_stage_config = s.isc;
    assign o_ext_pin_digital    = s.ext_digital;
    assign o_fast_debug_enable  = s.dbg_en;
    assign o_uart_enable        = s.uart_en;
    assign o_phase_valid        = s.out_valid;
    assign o_phase              = s.out_word;

    // Checks on the block's own behaviour
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n);

    property p_raw_no_mid;
        !(s.raw[0] == 16'h8000 || s.raw[1] == 16'h8000 ||
          s.raw[2] == 16'h8000 || s.raw[3] == 16'h8000);
    endproperty
    a_raw_no_mid: assert property (p_raw_no_mid)
        else $error("raw code at midscale not mapped to 7fff");

    property p_dbg_off;
        (i_mod_mode != cas_pkg::cas_mode_analog) |=> !o_fast_debug_enable;
    endproperty
    a_dbg_off: assert property (p_dbg_off)
        else $error("fast debug port on in external mode");

    property p_uart_on;
        o_uart_enable;
    endproperty
    a_uart_on: assert property (p_uart_on)
        else $error("debug uart disabled");

    property p_pin_digital;
        (i_mod_mode != cas_pkg::cas_mode_analog) |=> o_ext_pin_digital;
    endproperty
    a_pin_digital: assert property (p_pin_digital)
        else $error("analog pin not switched to digital");

    property p_clk_in_release;
        (i_mod_mode == cas_pkg::cas_mode_clk_in) |=> (o_mclk_oe_n == 2'b11);
    endproperty
    a_clk_in_release: assert property (p_clk_in_release)
        else $error("clock pin driven in clock input mode");

    property p_clk_out_nco;
        (i_mod_mode == cas_pkg::cas_mode_clk_out) |=>
            (o_mclk_oe_n == 2'b00 && o_mclk_out == {2{s.acc[31]}});
    endproperty
    a_clk_out_nco: assert property (p_clk_out_nco)
        else $error("clock pin does not follow the nco");

    property p_unity_gain;
        (s.gain0 == 16'h0100 && s.ofs0 == 16'h0000 && !s.raw_first[15])
            |-> (corr0 == $signed(s.raw_first));
    endproperty
    a_unity_gain: assert property (p_unity_gain)
        else $error("unity gain does not pass raw value");

    property p_saturate;
        (s.gain0 == 16'h7fff && s.ofs0 == 16'h0000 && s.raw_first == 16'hffff)
            |-> (corr0 == 16'sh7fff);
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("scaled current wraps instead of saturating");

    property p_third_sum;
        (i_three_phase_mode && corr0 < 16'sd16000 && corr0 > -16'sd16000 &&
         corr1 < 16'sd16000 && corr1 > -16'sd16000)
            |-> (18'(corr0) + 18'(corr1) + 18'(third) == 18'h0);
    endproperty
    a_third_sum: assert property (p_third_sum)
        else $error("three phase currents do not sum to zero");

    property p_no_third;
        !i_three_phase_mode |-> (third == 16'sh0000);
    endproperty
    a_no_third: assert property (p_no_third)
        else $error("third current computed in two phase mode");

    property p_raw_read;
        (i_reg_addr == `CAS_ADDR_RAW_PAIR) |=>
            (o_reg_rdata == {$past(s.raw_second), $past(s.raw_first)});
    endproperty
    a_raw_read: assert property (p_raw_read)
        else $error("raw pair read returns wrong data");

    c_three_push: cover property (i_three_phase_mode && take);
    c_fifo_full: cover property (s.s2_valid && !fifo_in_ready);
    c_clk_in_word: cover property (
        i_mod_mode == cas_pkg::cas_mode_clk_in && s.new_raw);
    c_phase_out: cover property (o_phase_valid && i_phase_ready);
endmodule

`default_nettype wire

// ### test/cas_mod_model.sv
// Modulator model giving bitstreams of fixed ones-density
`timescale 1ns/1ps
`default_nettype none
module cas_mod_model (
    input  wire logic  i_clk_sys,
    input  wire logic  i_mclk,
    output logic [3:0] o_bits
);
    logic [1:0] step = 2'h0;
    logic       mclk_d = 1'b0;
    // Advance the pattern on each modulator clock rise
    always @(posedge i_clk_sys) begin
        mclk_d <= i_mclk;
        if (i_mclk && !mclk_d) step <= step + 2'h1;
    end
    // Empty, full, half and quarter density
    assign o_bits = {1'b0, 1'b1, step[0], step == 2'h0};
endmodule
`default_nettype wire

// ### test/cas_scaler_bench.sv
// Self-checking bench of the current scaler and selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module cas_scaler_bench;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, three = 1'b1;
    logic [6:0]  addr = 7'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [3:0]  isc = 4'h0, isc_o, bits;
    logic [1:0]  mco, oe_n;
    logic        imc, dig, dbg, uart, pv;
    cas_pkg::cas_mod_mode_t   mode = cas_pkg::cas_mode_analog;
    cas_pkg::cas_raw_src_t    s0 = cas_pkg::cas_src_int_u;
    cas_pkg::cas_raw_src_t    s1 = cas_pkg::cas_src_int_v;
    cas_pkg::cas_phase_word_t ph, pw;
    int err_total = 0, checks = 0, cyc = 0;
    always #5 clk = ~clk;
    cas_mod_model pm (.i_clk_sys(clk), .i_mclk(imc), .o_bits(bits));
    cas_scaler uut (.i_clk_sys(clk), .i_resetn(rst_n), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_modulator_bitstream(bits), .i_mclk_in(2'b00), .o_mclk_out(mco),
        .o_mclk_oe_n(oe_n), .o_int_mclk(imc), .i_mod_mode(mode),
        .i_mclk_increment(32'h40000000), .i_decimation_log2(3'h2),
        .i_input_stage_config(isc), .o_input_stage_config(isc_o),
        .o_ext_pin_digital(dig), .o_fast_debug_enable(dbg),
        .o_uart_enable(uart), .i_raw_source_sel_first(s0),
        .i_raw_source_sel_second(s1),
        .i_phase_ux_source_sel(cas_pkg::cas_ph_first),
        .i_phase_v_source_sel(cas_pkg::cas_ph_second),
        .i_phase_wy_source_sel(cas_pkg::cas_ph_third),
        .i_three_phase_mode(three), .o_phase_valid(pv), .i_phase_ready(1'b1),
        .o_phase(ph));
    task print_verdict;
        if (err_total == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict;
        end
    end
    task wr_reg(input logic [6:0] a, input logic [31:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task rd_reg(input logic [6:0] a);
        @(posedge clk) addr <= a;
        repeat (2) @(posedge clk);
        #1 rv = rdata;
    endtask
    // Settle, then take the next word offered
    task get_ph;
        repeat (120) @(posedge clk);
        repeat (50) begin
            @(posedge clk);
            #1 if (pv === 1'b1) break;
        end
        `CHK("phase valid", 1'b1, pv)
        pw = ph;
    endtask
    task t_regs;
        rd_reg(7'h09); `CHK("ofs gain 09", 32'h01008000, rv)
        wr_reg(7'h08, 32'h02001234); wr_reg(7'h02, 32'h12345678);
        rd_reg(7'h08); `CHK("ofs gain 08", 32'h02001234, rv)
        rd_reg(7'h05); `CHK("unmapped", 32'h0, rv)
        wr_reg(7'h08, 32'h01008000);
    endtask
    task t_modes;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) mode <= cas_pkg::cas_mod_mode_t'(i);
            repeat (3) @(posedge clk);
            #1 `CHK("pin digital", i != 0, dig)
            `CHK("fast debug", i == 0, dbg)
            `CHK("uart", 1'b1, uart)
            `CHK("clk pin drive", i == 0 || i == 2, oe_n[0])
        end
        @(posedge clk) begin mode <= cas_pkg::cas_mode_analog; isc <= 4'h9; end
        repeat (2) @(posedge clk);
        #1 `CHK("stage cfg", 4'h9, isc_o)
    endtask
    task t_raw;
        repeat (300) @(posedge clk);
        rd_reg(7'h02); `CHK("raw pair", 32'h7fff4000, rv)
        get_ph; `CHK("phase 3ph", 48'hc000ffff4001, pw)
        wr_reg(7'h09, 32'h03008000);
        get_ph; `CHK("phase sat", 48'h8000ffff7fff, pw)
        wr_reg(7'h09, 32'h01000000);
        get_ph; `CHK("phase unity", 48'h4000ffffc001, pw)
        wr_reg(7'h09, 32'h01008000);
        @(posedge clk) three <= 1'b0;
        get_ph; `CHK("phase 2ph", 48'hc000ffff0000, pw)
    endtask
    task t_ext;
        @(posedge clk) begin mode <= cas_pkg::cas_mode_clk_out;
            s0 <= cas_pkg::cas_src_ext_0; s1 <= cas_pkg::cas_src_ext_1; end
        repeat (300) @(posedge clk);
        #1 `CHK("clk pin drive", 1'b0, oe_n[0])
        `CHK("clk pin value", {2{imc}}, mco)
        rd_reg(7'h02); `CHK("ext raw pair", 32'h0000ffff, rv)
        wr_reg(7'h09, 32'h7fff0000);
        get_ph; `CHK("phase ext sat", 48'h7fff80000000, pw)
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs; t_modes; t_raw; t_ext;
        print_verdict;
    end
endmodule
`default_nettype wire
